// *** ibp_host.sv ***
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module ibp_host #(
    parameter int RC_CYC = ibp_pkg::RC_DELAY_CYC,
    parameter int WR_CYC = ibp_pkg::WR_PULSE_CYC
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    ibp_bus_if.host bus,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata
);
    import ibp_pkg::*;

    if (RC_CYC < 2 || RC_CYC > 255 || WR_CYC < 2 || WR_CYC > 255) begin : g_bad_wait
        $error("ibp_host: wait counts must be 2..255");
    end

    // split key code into column and row digits
    function automatic logic [7:0] key_pos(input logic [6:0] code);
        logic [6:0] col;
        logic [6:0] row;
        col = code / 7'd10 + 7'd1;
        row = code % 7'd10 + 7'd1;
        return {col[3:0], row[3:0]};
    endfunction

    ibp_hstate_type st_q;
    logic [7:0] cnt_q;
    logic auto_poll_q;
    logic [7:0] tgt_addr_q;
    logic [7:0] tgt_wdata_q;
    logic [7:0] read_data_q;
    logic [7:0] poll_byte_q;
    logic [7:0] addr_q;
    logic [7:0] data_q;
    logic data_oe_q;
    logic strobe_n_q;
    logic poll_q;
    logic [7:0] rdata_q;
    logic cmd_wr;
    logic srq_seen;

    assign cmd_wr = i_wr && (i_addr == HREG_CMD) && (st_q == H_IDLE);
    assign srq_seen = ~bus.service_request_n;

    // ---------------------------------------------
    // software registers
    // ---------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            auto_poll_q <= 1'b0;
            tgt_addr_q <= ADDR_UNADDR;
            tgt_wdata_q <= 8'h00;
        end else if (i_wr) begin
            case (i_addr)
                HREG_CTRL: auto_poll_q <= i_wdata[0];
                HREG_BUS_ADDR: tgt_addr_q <= i_wdata;
                HREG_BUS_WDATA: tgt_wdata_q <= i_wdata;
                default: ;
            endcase
        end
    end

    // read port, data valid only the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            rdata_q <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                HREG_CTRL: rdata_q <= {7'h00, auto_poll_q};
                HREG_BUS_ADDR: rdata_q <= tgt_addr_q;
                HREG_BUS_WDATA: rdata_q <= tgt_wdata_q;
                HREG_STATUS: rdata_q <= {6'h00, srq_seen, st_q != H_IDLE};
                HREG_READ_DATA: rdata_q <= read_data_q;
                HREG_POLL_BYTE: rdata_q <= poll_byte_q; // see RQ10
                HREG_KEY_POS: rdata_q <= key_pos(read_data_q[6:0]); // see RQ16
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign o_rdata = rdata_q;

    // ---------------------------------------------
    // bus sequencer
    // ---------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            st_q <= H_IDLE;
            cnt_q <= 8'h00;
            addr_q <= ADDR_UNADDR;
            data_q <= BUS_IDLE;
            data_oe_q <= 1'b0;
            strobe_n_q <= 1'b1;
            poll_q <= 1'b0;
            read_data_q <= 8'h00;
            poll_byte_q <= 8'hFF;
        end else begin
            case (st_q)
                H_IDLE: begin
                    if (cmd_wr && i_wdata == CMD_WRITE) begin
                        addr_q <= tgt_addr_q;
                        data_q <= tgt_wdata_q;
                        st_q <= H_W_SETUP;
                    end else if (cmd_wr && i_wdata == CMD_READ) begin
                        addr_q <= tgt_addr_q;
                        strobe_n_q <= 1'b0; // see RQ1
                        cnt_q <= 8'(RC_CYC);
                        st_q <= H_R_STROBE;
                    end else if ((cmd_wr && i_wdata == CMD_POLL) || (auto_poll_q && srq_seen)) begin
                        addr_q <= ADDR_POLL_OPEN; // see RQ3 RQ7
                        st_q <= H_P_ADDR;
                    end
                end
                H_W_SETUP: begin
                    data_oe_q <= 1'b1; // device has let go by now, unless the target address is F4
                    strobe_n_q <= 1'b0; // see RQ20
                    cnt_q <= 8'(WR_CYC);
                    st_q <= H_W_STROBE;
                end
                H_W_STROBE: begin
                    if (cnt_q == 8'h01) begin
                        strobe_n_q <= 1'b1;
                        data_oe_q <= 1'b0;
                        st_q <= H_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                H_R_STROBE: begin
                    if (cnt_q == 8'h01) begin
                        read_data_q <= bus.data; // see RQ2
                        strobe_n_q <= 1'b1;
                        st_q <= H_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                H_P_ADDR: begin
                    poll_q <= 1'b1; // see RQ4
                    st_q <= H_P_RAISE;
                end
                H_P_RAISE: begin
                    strobe_n_q <= 1'b0;
                    cnt_q <= 8'(RC_CYC);
                    st_q <= H_P_STROBE;
                end
                H_P_STROBE: begin
                    if (cnt_q == 8'h01) begin
                        poll_byte_q <= bus.data;
                        strobe_n_q <= 1'b1;
                        poll_q <= 1'b0; // see RQ8
                        addr_q <= ADDR_UNADDR;
                        st_q <= H_P_END;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                H_P_END: begin
                    poll_q <= 1'b1; // see RQ9
                    data_q <= poll_byte_q;
                    data_oe_q <= 1'b1;
                    strobe_n_q <= 1'b0;
                    cnt_q <= 8'(WR_CYC);
                    st_q <= H_P_WB;
                end
                H_P_WB: begin
                    if (cnt_q == 8'h01) begin
                        strobe_n_q <= 1'b1;
                        data_oe_q <= 1'b0;
                        poll_q <= 1'b0;
                        cnt_q <= 8'(COOL_CYC);
                        st_q <= H_P_COOL;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                H_P_COOL: begin
                    if (cnt_q == 8'h01) begin
                        st_q <= H_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end

    assign bus.addr = addr_q;
    assign bus.host_data = data_q;
    assign bus.host_data_oe = data_oe_q;
    assign bus.strobe_n = strobe_n_q;
    assign bus.poll = poll_q;
endmodule

// *** ibp_pkg.sv ***
// Overview of operation
// RQ1: host asserts read strobe by control write
// RQ2: host waits delay, samples, releases strobe
// RQ3: poll opens with FF; decoders ignore it
// RQ4: host then raises poll request line
// RQ5: pending board pulls its line during poll
// RQ6: poll bits: 4 sweep,3 knob,2 lock,0 keys
// RQ7: service request starts host poll routine
// RQ8: poll drop and 7F disable and unaddress
// RQ9: next poll rise arms; writeback clears reads
// RQ10: host merges poll status with gpib status; here the poll byte is only kept in its own register, HREG_POLL_BYTE
// RQ11: 74 selects input, F4 selects output path
// RQ12: lines 0,1,2,4 feed four LED shifters
// RQ13: fourth shifter MSB drives graticule light
// RQ14: line 3 drives power-up control directly
// RQ15: output lines 0-6 carry key code
// RQ16: host splits code into column and row
// RQ17: output line 7 gives knob direction
// RQ18: output buffer drives only when addressed
// RQ19: both encoders request service on change
// RQ20: host write strobe pulses automatically
// RQ21: key poll bit low with service request
// RQ22: decoders compare all eight address bits
package ibp_pkg;
    // ---------------------------------------------
    // bus addresses and bit positions
    // ---------------------------------------------
    localparam logic [7:0] ADDR_LED_IN = 8'h74;
    localparam logic [7:0] ADDR_ENC_OUT = 8'hF4;
    localparam logic [7:0] ADDR_POLL_OPEN = 8'hFF;
    localparam logic [7:0] ADDR_UNADDR = 8'h7F;
    localparam logic [7:0] BUS_IDLE = 8'hFF;
    localparam int POLL_BIT_SWEEP = 4;
    localparam int POLL_BIT_KNOB = 3;
    localparam int POLL_BIT_LOCK = 2;
    localparam int POLL_BIT_KEYS = 0;
    localparam int LED_DB_BIT [4] = '{0, 1, 2, 4};
    localparam int POWER_UP_BIT = 3;
    localparam int DIR_BIT = 7;
    localparam int CODE_W = 7;
    localparam int LED_LEN = 8;
    // ---------------------------------------------
    // timing
    // ---------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int RC_DELAY_NS = 1000;
    localparam int WR_PULSE_NS = 500;
    localparam int RC_DELAY_CYC = (RC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_PULSE_CYC = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int COOL_CYC = 3;
    // ---------------------------------------------
    // host register map and commands
    // ---------------------------------------------
    localparam logic [2:0] HREG_CTRL = 3'h0;
    localparam logic [2:0] HREG_BUS_ADDR = 3'h1;
    localparam logic [2:0] HREG_BUS_WDATA = 3'h2;
    localparam logic [2:0] HREG_CMD = 3'h3;
    localparam logic [2:0] HREG_STATUS = 3'h4;
    localparam logic [2:0] HREG_READ_DATA = 3'h5;
    localparam logic [2:0] HREG_POLL_BYTE = 3'h6;
    localparam logic [2:0] HREG_KEY_POS = 3'h7;
    localparam logic [7:0] CMD_WRITE = 8'h01;
    localparam logic [7:0] CMD_READ = 8'h02;
    localparam logic [7:0] CMD_POLL = 8'h03;
    // ---------------------------------------------
    // state types
    // ---------------------------------------------
    typedef enum logic [3:0] {
        H_IDLE = 4'h0, H_W_SETUP = 4'h1, H_W_STROBE = 4'h3, H_R_STROBE = 4'h2,
        H_P_ADDR = 4'h6, H_P_RAISE = 4'h7, H_P_STROBE = 4'h5, H_P_END = 4'h4,
        H_P_WB = 4'hC, H_P_COOL = 4'hD
    } ibp_hstate_type;
    typedef enum logic [1:0] {
        D_LIVE = 2'h0, D_MUTED = 2'h1, D_ARMED = 2'h3, D_CAUGHT = 2'h2
    } ibp_dstate_type;
endpackage

// *** ibp_bus_if.sv ***
`timescale 1ns/1ps
interface ibp_bus_if;
    logic [7:0] addr;
    logic [7:0] host_data;
    logic host_data_oe;
    logic [7:0] dev_data;
    logic dev_data_oe;
    logic strobe_n;
    logic poll;
    logic srq_oe;
    logic [7:0] data;
    logic service_request_n;
    // ---------------------------------------------
    // wired levels: pull-up with wired-and drivers
    // ---------------------------------------------
    assign data = (host_data_oe ? host_data : 8'hFF) & (dev_data_oe ? dev_data : 8'hFF);
    assign service_request_n = ~srq_oe;
    modport host (output addr, host_data, host_data_oe, strobe_n, poll,
                  input data, service_request_n);
    modport dev (input addr, strobe_n, poll, data,
                 output dev_data, dev_data_oe, srq_oe);
endinterface

// *** ibp_front_panel.sv ***
`timescale 1ns/1ps
module ibp_front_panel #(
    parameter int LEN = ibp_pkg::LED_LEN
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    ibp_bus_if.dev bus,
    input wire logic i_key_event,
    input wire logic [ibp_pkg::CODE_W-1:0] i_key_code,
    input wire logic i_knob_event,
    input wire logic i_knob_up,
    output logic [4*ibp_pkg::LED_LEN-2:0] o_mode_led,
    output logic o_graticule,
    output logic o_power_up
);
    import ibp_pkg::*;

    if (LEN != LED_LEN) begin : g_bad_len
        $error("ibp_front_panel: shifter length must match port width");
    end

    // full eight-bit address compare
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] want);
        return a == want; // see RQ22
    endfunction

    // ---------------------------------------------
    // bus edge tracking
    // ---------------------------------------------
    logic strobe_n_d1_q;
    logic poll_d1_q;
    logic strobe_on;
    logic strobe_fall;
    logic poll_rise;
    logic poll_fall;
    logic sel_in;
    logic sel_out;

    // previous levels for edge detection
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            strobe_n_d1_q <= 1'b1;
            poll_d1_q <= 1'b0;
        end else begin
            strobe_n_d1_q <= bus.strobe_n;
            poll_d1_q <= bus.poll;
        end
    end

    assign strobe_on = ~bus.strobe_n;
    assign strobe_fall = strobe_n_d1_q & ~bus.strobe_n;
    assign poll_rise = bus.poll & ~poll_d1_q;
    assign poll_fall = ~bus.poll & poll_d1_q;
    // FF and 7F match neither path
    assign sel_in = addr_hit(bus.addr, ADDR_LED_IN); // see RQ3 RQ8 RQ11
    assign sel_out = addr_hit(bus.addr, ADDR_ENC_OUT); // see RQ11

    // ---------------------------------------------
    // LED shifters and power-up drive
    // ---------------------------------------------
    logic [LEN-1:0] led_q [4];
    logic power_up_q;
    logic shift_en;

    assign shift_en = strobe_fall & sel_in & ~bus.poll;

    // one bit per strobe to 74, read or write, into each shifter
    generate
        for (genvar g = 0; g < 4; g++) begin : g_led
            always_ff @(posedge i_clk) begin
                if (!i_reset_n) begin
                    led_q[g] <= '0;
                end else if (shift_en) begin
                    led_q[g] <= {led_q[g][LEN-2:0], bus.data[LED_DB_BIT[g]]}; // see RQ12
                end
            end
        end
    endgenerate

    // unlatched: high only while any strobe to 74 sees the bit high
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            power_up_q <= 1'b0;
        end else begin
            power_up_q <= strobe_on & sel_in & ~bus.poll & bus.data[POWER_UP_BIT]; // see RQ14
        end
    end

    assign o_mode_led = {led_q[3][LEN-2:0], led_q[2], led_q[1], led_q[0]};
    assign o_graticule = led_q[3][LEN-1]; // see RQ13
    assign o_power_up = power_up_q;

    // ---------------------------------------------
    // encoder capture and pending requests
    // ---------------------------------------------
    logic [CODE_W-1:0] code_q;
    logic dir_q;
    logic key_pend_q;
    logic knob_pend_q;
    logic clr_key_q;
    logic clr_knob_q;
    logic clear_now;
    ibp_dstate_type st_q;

    assign clear_now = (st_q == D_CAUGHT) & poll_fall;

    // latest key code and knob direction
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            code_q <= '0;
            dir_q <= 1'b0;
        end else begin
            if (i_key_event) begin
                code_q <= i_key_code;
            end
            if (i_knob_event) begin
                dir_q <= i_knob_up;
            end
        end
    end

    // new change wins over a clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            key_pend_q <= 1'b0;
        end else if (i_key_event) begin
            key_pend_q <= 1'b1; // see RQ19
        end else if (clear_now & clr_key_q) begin
            key_pend_q <= 1'b0; // see RQ9
        end
    end

    // knob request, same handling
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            knob_pend_q <= 1'b0;
        end else if (i_knob_event) begin
            knob_pend_q <= 1'b1; // see RQ19
        end else if (clear_now & clr_knob_q) begin
            knob_pend_q <= 1'b0; // see RQ9
        end
    end

    // ---------------------------------------------
    // poll response arming
    // ---------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            st_q <= D_LIVE;
            clr_key_q <= 1'b0;
            clr_knob_q <= 1'b0;
        end else begin
            case (st_q)
                D_LIVE: begin
                    if (poll_fall) begin
                        st_q <= D_MUTED; // see RQ8
                    end
                end
                D_MUTED: begin
                    if (poll_rise) begin
                        st_q <= D_ARMED; // see RQ9
                    end
                end
                D_ARMED: begin
                    if (poll_fall) begin
                        st_q <= D_LIVE;
                    end else if (strobe_on & bus.poll) begin
                        clr_key_q <= ~bus.data[POLL_BIT_KEYS]; // see RQ9
                        clr_knob_q <= ~bus.data[POLL_BIT_KNOB];
                        st_q <= D_CAUGHT;
                    end
                end
                D_CAUGHT: begin
                    if (poll_fall) begin
                        clr_key_q <= 1'b0;
                        clr_knob_q <= 1'b0;
                        st_q <= D_LIVE;
                    end
                end
                default: st_q <= D_LIVE;
            endcase
        end
    end

    // ---------------------------------------------
    // bus drivers
    // ---------------------------------------------
    logic [7:0] dev_data_q;
    logic dev_oe_q;
    logic srq_q;

    // service request follows any pending source
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            srq_q <= 1'b0;
        end else begin
            srq_q <= key_pend_q | knob_pend_q; // see RQ19 RQ21
        end
    end

    // poll answer or encoder word, released otherwise
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            dev_data_q <= BUS_IDLE;
            dev_oe_q <= 1'b0;
        end else if (bus.poll & strobe_on & (st_q == D_LIVE) & (key_pend_q | knob_pend_q)) begin
            dev_data_q <= BUS_IDLE; // see RQ5 RQ6
            dev_data_q[POLL_BIT_KEYS] <= ~key_pend_q; // see RQ21
            dev_data_q[POLL_BIT_KNOB] <= ~knob_pend_q;
            dev_oe_q <= 1'b1;
        end else if (sel_out & ~bus.poll) begin
            dev_data_q <= {dir_q, code_q}; // see RQ15 RQ17
            dev_oe_q <= 1'b1; // see RQ18
        end else begin
            dev_data_q <= BUS_IDLE;
            dev_oe_q <= 1'b0; // see RQ18
        end
    end

    assign bus.dev_data = dev_data_q;
    assign bus.dev_data_oe = dev_oe_q;
    assign bus.srq_oe = srq_q;
endmodule

// *** ibp_checker.sv ***
`timescale 1ns/1ps
module ibp_checker #(
    parameter int RC_CYC = 10,
    parameter int WR_CYC = 5
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] host_data,
    input wire logic host_data_oe,
    input wire logic [7:0] dev_data,
    input wire logic dev_data_oe,
    input wire logic strobe_n,
    input wire logic poll,
    input wire logic srq_oe,
    input wire logic [7:0] data,
    input wire logic service_request_n
);
    import ibp_pkg::*;
    int low_cnt_q;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // ---------------------------------------------
    // strobe low-time counter
    // ---------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || strobe_n) begin
            low_cnt_q <= 0;
        end else begin
            low_cnt_q <= low_cnt_q + 1;
        end
    end
    // ---------------------------------------------
    // properties
    // ---------------------------------------------
    buffer_enable_a: assert property (
        dev_data_oe |-> ($past(addr) == ADDR_ENC_OUT && !$past(poll)) || ($past(poll) && !$past(strobe_n)))
        else $error("device drove bus while not addressed");
    decode_miss_a: assert property (
        addr != ADDR_ENC_OUT && !poll |=> !dev_data_oe) else $error("device drove an unselected address");
    poll_unused_a: assert property (
        dev_data_oe && $past(poll) |-> dev_data[7:4] == 4'hF && dev_data[2:1] == 2'b11)
        else $error("unused poll bit pulled low");
    key_bit_srq_a: assert property (
        dev_data_oe && $past(poll) && !dev_data[0] |-> srq_oe) else $error("key poll bit without request");
    poll_rise_addr_a: assert property (
        $rose(poll) |-> addr == ADDR_POLL_OPEN || addr == ADDR_UNADDR) else $error("poll raised on valid address");
    poll_fall_addr_a: assert property (
        $fell(poll) |-> addr == ADDR_UNADDR) else $error("poll dropped without unaddress");
    write_strobe_a: assert property (
        $rose(strobe_n) && $past(host_data_oe) |-> low_cnt_q == WR_CYC && !host_data_oe)
        else $error("write strobe length wrong");
    read_strobe_a: assert property (
        $rose(strobe_n) && !$past(host_data_oe) |-> low_cnt_q inside {[RC_CYC:RC_CYC + 1]})
        else $error("read strobe released early");
    strobe_hold_a: assert property (
        !strobe_n && !$past(strobe_n) |-> $stable(addr) && $stable(poll)) else $error("bus moved under strobe");
    no_contention_a: assert property (
        !(host_data_oe && dev_data_oe)) else $error("both ends drive data");
    cover property ($fell(poll) ##1 $rose(poll));
    cover property ($rose(strobe_n) && $past(host_data_oe));
    cover property (dev_data_oe && addr == ADDR_ENC_OUT);
endmodule

// *** tb_instrument_bus_poll_port.sv ***
`timescale 1ns/1ps
module tb_instrument_bus_poll_port;
    import ibp_pkg::*;
    localparam int RC = 3;
    localparam int WR = 2;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic i_key_event = 1'b0;
    logic [6:0] i_key_code = 7'h00;
    logic i_knob_event = 1'b0;
    logic i_knob_up = 1'b0;
    logic [30:0] o_mode_led;
    logic o_graticule;
    logic o_power_up;
    logic [7:0] exp_q[$];
    logic [7:0] msk_q[$];
    logic rd_seen = 1'b0;
    logic wr_low = 1'b0;
    logic [7:0] led[4];
    logic [7:0] last;
    logic [7:0] exp_read = 8'h00;
    int fails = 0;
    int checks = 0;
    ibp_bus_if bus_if();
    ibp_host #(.RC_CYC(RC), .WR_CYC(WR)) ibp_host_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(bus_if),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
    ibp_front_panel ibp_front_panel_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(bus_if),
        .i_key_event(i_key_event), .i_key_code(i_key_code), .i_knob_event(i_knob_event), .i_knob_up(i_knob_up),
        .o_mode_led(o_mode_led), .o_graticule(o_graticule), .o_power_up(o_power_up));
    ibp_checker #(.RC_CYC(RC), .WR_CYC(WR)) ibp_checker_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .addr(bus_if.addr), .host_data(bus_if.host_data), .host_data_oe(bus_if.host_data_oe),
        .dev_data(bus_if.dev_data), .dev_data_oe(bus_if.dev_data_oe), .strobe_n(bus_if.strobe_n),
        .poll(bus_if.poll), .srq_oe(bus_if.srq_oe), .data(bus_if.data),
        .service_request_n(bus_if.service_request_n));
    // ---------------------------------------------
    // compare and report
    // ---------------------------------------------
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ---------------------------------------------
    // register port and bus tasks
    // ---------------------------------------------
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 last = o_rdata;
    endtask
    task automatic wait_idle();
        for (int n = 0; n < 100; n++) begin
            reg_rd(HREG_STATUS, 8'h00, 8'h00);
            if (last[0] === 1'b0) return;
        end
        fails++;
        end_of_test();
    endtask
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        reg_wr(HREG_BUS_ADDR, a);
        reg_wr(HREG_BUS_WDATA, d);
        reg_wr(HREG_CMD, CMD_WRITE);
        wait_idle();
    endtask
    task automatic bus_read(input logic [7:0] a, input logic [7:0] e);
        reg_wr(HREG_BUS_ADDR, a);
        reg_wr(HREG_CMD, CMD_READ);
        wait_idle();
        reg_rd(HREG_READ_DATA, e, 8'hFF);
    endtask
    task automatic poll_cycle(input logic [7:0] e);
        reg_wr(HREG_CMD, CMD_POLL);
        wait_idle();
        reg_rd(HREG_POLL_BYTE, e, 8'hFF);
    endtask
    // one key or knob event, with its expected read value
    task automatic fire(input logic key, input logic [6:0] c, input logic up);
        @(posedge i_clk);
        i_key_code <= c;
        i_knob_up <= up;
        i_key_event <= key;
        i_knob_event <= !key;
        @(posedge i_clk);
        i_key_event <= 1'b0;
        i_knob_event <= 1'b0;
        if (key) exp_read[6:0] = c;
        else exp_read[7] = up;
    endtask
    // ---------------------------------------------
    // watchers: register answers and wire levels
    // ---------------------------------------------
    always @(posedge i_clk) begin
        if (rd_seen && exp_q.size() > 0) begin
            if (msk_q[0] != 8'h00) check(o_rdata & msk_q[0], exp_q[0] & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
        rd_seen <= i_rd;
        if (!bus_if.strobe_n && bus_if.host_data_oe && !bus_if.poll && bus_if.addr == ADDR_LED_IN) begin
            if (wr_low) check(o_power_up, bus_if.data[POWER_UP_BIT]);
            wr_low <= 1'b1;
        end else begin
            wr_low <= 1'b0;
        end
        if (bus_if.dev_data_oe === 1'b1 && !bus_if.poll && bus_if.addr == ADDR_ENC_OUT)
            check(bus_if.data, exp_read);
    end
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        logic [7:0] d;
        logic [6:0] c;
        void'($urandom(32'h41EB));
        repeat (20) @(posedge i_clk);
        i_reset_n <= 1'b1;
        check({bus_if.addr, bus_if.strobe_n, bus_if.poll, bus_if.service_request_n}, {ADDR_UNADDR, 3'b101});
        check({o_mode_led, o_graticule, o_power_up}, 0);
        reg_rd(HREG_CMD, 8'h00, 8'hFF);
        // eight shifts into the LEDs, a ninth write elsewhere
        led = '{default: 8'h00};
        for (int i = 0; i < 9; i++) begin
            d = 8'($urandom);
            d[POWER_UP_BIT] = i[0];
            bus_write(i == 8 ? 8'h75 : ADDR_LED_IN, d);
            for (int k = 0; k < 4 && i < 8; k++) begin
                led[k] = {led[k][6:0], d[LED_DB_BIT[k]]};
            end
        end
        check({o_graticule, o_mode_led}, {led[3], led[2], led[1], led[0]});
        // both encoders report, then the code is read back
        c = 7'($urandom_range(127));
        fire(1'b1, c, 1'b0);
        fire(1'b0, 7'h00, 1'b1);
        reg_rd(HREG_STATUS, 8'h02, 8'h02);
        check(bus_if.service_request_n, 1'b0);
        bus_read(ADDR_ENC_OUT, {1'b1, c});
        reg_rd(HREG_KEY_POS, {4'(int'(c) / 10 + 1), 4'(int'(c) % 10 + 1)}, 8'hFF);
        bus_read(8'h75, 8'hFF);
        bus_read(ADDR_POLL_OPEN, 8'hFF);
        bus_read(ADDR_UNADDR, 8'hFF);
        // poll, clear, poll again
        poll_cycle(8'hF6);
        check(bus_if.service_request_n, 1'b1);
        poll_cycle(8'hFF);
        fire(1'b1, 7'h1D, 1'b0);
        poll_cycle(8'hFE);
        // automatic poll on a knob request
        reg_wr(HREG_CTRL, 8'h01);
        reg_rd(HREG_CTRL, 8'h01, 8'hFF);
        fire(1'b0, 7'h00, 1'b0);
        repeat (5) @(posedge i_clk);
        wait_idle();
        reg_rd(HREG_POLL_BYTE, 8'hF7, 8'hFF);
        check(bus_if.service_request_n, 1'b1);
        reg_wr(HREG_CTRL, 8'h00);
        bus_read(ADDR_ENC_OUT, 8'h1D);
        reg_rd(HREG_KEY_POS, 8'h3A, 8'hFF);
        repeat (2) @(posedge i_clk);
        end_of_test();
    end
endmodule
